// ===== dv/vrc_voltage_reference_control_monitor.sv
`timescale 1ns/1ps
module vrc_voltage_reference_control_monitor (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_sel,
  input wire vrc_pkg::vrc_consumer_type consumers,
  input wire vrc_pkg::vrc_analog_type analog
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  wire wr = sfr_wr && sfr_sel;
  sequence wr_gap_rd; wr ##1 !sfr_wr ##1 (sfr_rd && sfr_sel && !sfr_wr); endsequence
  AST_SRC: assert property (wr |=> analog.ref_mux_vdd == $past(sfr_wdata[3])) else $error("src");
  AST_LVL: assert property (wr |=> analog.ref_level_high == $past(sfr_wdata[4])) else $error("lvl");
  AST_BUF: assert property (wr |=> analog.ref_pin_drive == $past(sfr_wdata[0])) else $error("buf");
  AST_BIAS: assert property (|consumers |=> analog.bias_on) else $error("bias forced");
  AST_BSW: assert property (wr && sfr_wdata[1] |=> analog.bias_on) else $error("bias sw");
  AST_TEMP: assert property (analog.temp_sensor_on != analog.temp_sensor_hiz) else $error("tmp");
  AST_MRG: assert property (wr |=> analog.dac2_to_first_pin == $past(sfr_wdata[7])) else $error("mrg");
  AST_ZTC: assert property (|consumers |=> analog.ztc_bias_on) else $error("ztc");
  AST_RB: assert property (wr_gap_rd |=> sfr_rdata == $past(sfr_wdata, 3)) else $error("rb");
endmodule

// ===== dv/vrc_voltage_reference_control_tb.sv
`timescale 1ns/1ps
module vrc_voltage_reference_control_tb;
  logic sys_clk = 0, arst_n = 0, sfr_wr = 0, sfr_rd = 0, sfr_sel;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  vrc_pkg::vrc_consumer_type consumers = '0;
  vrc_pkg::vrc_analog_type analog;
  int err_count = 0, num_checks = 0, cyc = 0;
  vrc_voltage_reference_control dut_u (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .sfr_sel(sfr_sel),
    .consumers(consumers),
    .analog(analog)
  );
  initial forever #20 sys_clk = ~sys_clk;
  // generous: whole run is well under a hundred cycles
  always @(posedge sys_clk) if (++cyc == 2000) begin
    err_count++;
    print_verdict;
  end
  ////////////////////////////////////////////////////////////////
  task print_verdict;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: %h vs %h", $time, g, e);
    end
  endtask
  // sensor counts as a bias consumer too
  function automatic vrc_pkg::vrc_analog_type ex(logic [7:0] r, logic [3:0] c);
    logic n;
    n = |c | r[2];
    return {r[3], r[4], r[0], r[0], r[1] | n, r[5] | n, r[2], !r[2], !r[7], r[7]};
  endfunction
  task acc(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge sys_clk);
    #1 {sfr_addr, sfr_wdata, sfr_wr, sfr_rd} = {a, d, w, !w};
    @(posedge sys_clk);
    #1 {sfr_wr, sfr_rd} = 2'b00;
  endtask
  task scen_bit(input logic [7:0] v);
    acc(8'hd1, v, 1);
    chk(sfr_sel, 1'b1);
    chk(analog, ex(v, consumers));
    acc(8'hd1, 8'h00, 0);
    chk(sfr_rdata, v);
  endtask
  task scen_cons;
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk) #1 consumers = 4'h1 << i;
      // switches are registered: demand shows after the next edge
      @(posedge sys_clk) #1 chk(analog, ex(8'h00, consumers));
    end
    @(posedge sys_clk) #1 consumers = '0;
    @(posedge sys_clk) #1 chk(analog, ex(8'h00, consumers));
  endtask
  task scen_unmapped;
    acc(8'hd0, 8'hff, 1);
    chk(sfr_sel, 1'b0);
    acc(8'hd0, 8'h00, 0);
    chk(sfr_rdata, 8'h00);
    acc(8'hd1, 8'h00, 0);
    chk(sfr_rdata, 8'h00);
  endtask
  // reset in mid-run must clear everything a full write had set
  task scen_reset;
    acc(8'hd1, 8'hff, 1);
    chk(analog, ex(8'hff, consumers));
    @(posedge sys_clk) #1 arst_n = 0;
    #1 chk(analog, ex(8'h00, 4'h0));
    @(posedge sys_clk) #1 arst_n = 1;
    acc(8'hd1, 8'h00, 0);
    chk(sfr_rdata, 8'h00);
    acc(8'hd1, 8'h00, 1);
    chk(analog, ex(8'h00, consumers));
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    #1 arst_n = 1;
    chk(analog, ex(8'h00, 4'h0));
    chk(sfr_rdata, 8'h00);
    for (int i = 0; i < 9; i++) scen_bit(8'h01 << i);
    scen_cons;
    scen_unmapped;
    scen_reset;
    print_verdict;
  end
endmodule
bind vrc_voltage_reference_control vrc_voltage_reference_control_monitor mon_u (
  .sys_clk(sys_clk),
  .arst_n(arst_n),
  .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata),
  .sfr_sel(sfr_sel),
  .consumers(consumers),
  .analog(analog)
);

// ===== hw/vrc_pkg.sv
package vrc_pkg;

  localparam logic [7:0] REF_CTRL_ADDR = 8'hd1;
  localparam logic [7:0] REF_CTRL_RESET = 8'h00;
  // read data between reads, and after reset
  localparam logic [7:0] RDATA_IDLE = 8'h00;

  localparam int BIT_BUFFER_EN = 0;
  localparam int BIT_BIAS_EN = 1;
  localparam int BIT_TEMP_EN = 2;
  localparam int BIT_SRC_SEL = 3;
  localparam int BIT_LEVEL_SEL = 4;
  localparam int BIT_ZTC_EN = 5;
  localparam int BIT_FLAG = 6;
  localparam int BIT_MERGE = 7;

  // field layout of the reference control register
  typedef struct packed {
    logic current_dac_merge_select;
    logic general_flag;
    logic zero_tc_bias_enable;
    logic ref_level_select;
    logic ref_source_select;
    logic temp_sensor_enable;
    logic bias_gen_enable;
    logic ref_buffer_enable;
  } vrc_ctrl_type;

  // analog steering outputs
  typedef struct packed {
    logic ref_mux_vdd;
    logic ref_level_high;
    logic ref_buffer_on;
    logic ref_pin_drive;
    logic bias_on;
    logic ztc_bias_on;
    logic temp_sensor_on;
    logic temp_sensor_hiz;
    logic dac2_to_own_pin;
    logic dac2_to_first_pin;
  } vrc_analog_type;

  // switches after reset: sensor isolated, second dac on its own pin, rest off
  localparam vrc_analog_type ANALOG_RESET = 10'h006;

  // peripherals that need the bias generator
  typedef struct packed {
    logic converter_en;
    logic oscillator_en;
    logic current_dac_first_en;
    logic current_dac_second_en;
  } vrc_consumer_type;

  typedef struct packed {
    vrc_ctrl_type ctrl;
    logic [7:0] rdata;
  } vrc_state_type;

endpackage

// ===== hw/vrc_voltage_reference_control.sv
// Functional notes
// R1: source select clear picks reference pin, set picks supply voltage.
// R2: level select clear gives 1.5 V, set gives 2.2 V.
// R3: buffer enable set turns buffer on and drives reference pin.
// R4: bias forced on while converter, sensor, oscillators or current DACs run.
// R5: software may force bias on by writing its enable bit.
// R6: sensor on when enabled; otherwise output high impedance, readings invalid.
// R7: merge clear keeps second DAC on own pin; set merges onto first.
// R8: software clears buffer enable when internal reference is unused.
// R9: software sets reference pin analog and skipped by crossbar.
// R10: zero-tc bias always on when set, else only while needed.
// R11: general flag stores written value, no hardware effect.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// address decode of the single register

module vrc_sfr_decode (
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic hit,
  output logic wr_hit,
  output logic rd_hit
);

  // handshake outputs, combinational so the core sees the select in the same cycle
  always_comb begin
    hit = (sfr_addr == vrc_pkg::REF_CTRL_ADDR);
    wr_hit = hit & sfr_wr;
    rd_hit = hit & sfr_rd;
  end

endmodule

////////////////////////////////////////////////////////////////////////////
// control register and registered readback

module vrc_ctrl_reg (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic wr_hit,
  input wire logic rd_hit,
  input wire logic [7:0] wdata,
  output vrc_pkg::vrc_ctrl_type ctrl_next,
  output logic [7:0] rdata
);

  vrc_pkg::vrc_state_type state_q;
  vrc_pkg::vrc_state_type state_d;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_d = state_q;
    if (wr_hit) begin
      // all eight bits are plain storage, none reserved
      state_d.ctrl = vrc_pkg::vrc_ctrl_type'(wdata); // R11
    end
    // read and write on one edge: the read returns the old value
    if (rd_hit) begin
      state_d.rdata = state_q.ctrl; // R11
    end else begin
      state_d.rdata = vrc_pkg::RDATA_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q.ctrl <= vrc_pkg::vrc_ctrl_type'(vrc_pkg::REF_CTRL_RESET);
      state_q.rdata <= vrc_pkg::RDATA_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // next value feeds the steering, so the switches move on the write edge itself
  assign ctrl_next = state_d.ctrl;
  assign rdata = state_q.rdata;

endmodule

////////////////////////////////////////////////////////////////////////////
// bias demand from the peripherals that lean on the generator

module vrc_bias_request (
  input wire vrc_pkg::vrc_consumer_type consumers,
  input wire logic temp_sensor_enable,
  output logic consumer_any
);

  // temperature sensor counts as a bias consumer too
  always_comb begin
    consumer_any = consumers.converter_en |
                   consumers.oscillator_en |
                   consumers.current_dac_first_en |
                   consumers.current_dac_second_en |
                   temp_sensor_enable; // R4
  end

endmodule

////////////////////////////////////////////////////////////////////////////
// analog steering, registered so no decode glitch reaches the switches

module vrc_steering (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire vrc_pkg::vrc_ctrl_type ctrl_next,
  input wire logic consumer_any,
  output vrc_pkg::vrc_analog_type analog
);

  vrc_pkg::vrc_analog_type steer_q;
  vrc_pkg::vrc_analog_type steer_d;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    steer_d = steer_q;

    steer_d.ref_mux_vdd = ctrl_next.ref_source_select; // R1
    steer_d.ref_level_high = ctrl_next.ref_level_select; // R2

    steer_d.ref_buffer_on = ctrl_next.ref_buffer_enable; // R3
    steer_d.ref_pin_drive = ctrl_next.ref_buffer_enable; // R3

    // readback keeps the software bit; the forcing only shows here
    steer_d.bias_on = ctrl_next.bias_gen_enable | consumer_any; // R4 R5
    // consumer demand lags by one edge, far inside any analog start-up time
    steer_d.ztc_bias_on = ctrl_next.zero_tc_bias_enable | consumer_any; // R10

    steer_d.temp_sensor_on = ctrl_next.temp_sensor_enable; // R6
    steer_d.temp_sensor_hiz = ~ctrl_next.temp_sensor_enable; // R6

    steer_d.dac2_to_own_pin = ~ctrl_next.current_dac_merge_select; // R7
    steer_d.dac2_to_first_pin = ctrl_next.current_dac_merge_select; // R7
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      steer_q <= vrc_pkg::ANALOG_RESET;
    end else begin
      steer_q <= steer_d;
    end
  end

  assign analog = steer_q;

endmodule

////////////////////////////////////////////////////////////////////////////
// top: glue only
// bus timing seen from the core:
//   edge n    strobe and address sampled, register, switches and read data updated
//   edge n+1  read data back to zero; it stood for exactly one cycle

module vrc_voltage_reference_control (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_sel,
  input wire vrc_pkg::vrc_consumer_type consumers,
  output vrc_pkg::vrc_analog_type analog
);

  logic wr_hit;
  logic rd_hit;
  logic consumer_any;
  vrc_pkg::vrc_ctrl_type ctrl_next;

  ////////////////////////////////////////////////////////////////////////////
  // register access

  vrc_sfr_decode decode_u (
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .hit(sfr_sel),
    .wr_hit(wr_hit),
    .rd_hit(rd_hit)
  );

  vrc_ctrl_reg ctrl_u (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .wr_hit(wr_hit),
    .rd_hit(rd_hit),
    .wdata(sfr_wdata),
    .ctrl_next(ctrl_next),
    .rdata(sfr_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // analog side

  vrc_bias_request bias_u (
    .consumers(consumers),
    .temp_sensor_enable(ctrl_next.temp_sensor_enable),
    .consumer_any(consumer_any)
  );

  vrc_steering steer_u (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .ctrl_next(ctrl_next),
    .consumer_any(consumer_any),
    .analog(analog)
  );

endmodule
